// file: pkg/irq_pkg.sv
// constants shared by the vectored interrupt unit
package irq_pkg;
  localparam int          NUM_SRC      = 11;
  localparam int          VEC_W        = 10;
  localparam int          ADDR_W       = 8;
  // vector table: reset at the bottom, sources follow in priority order
  localparam logic [9:0]  VEC_RESET    = 10'h000;
  localparam logic [9:0]  VEC_FIRST    = 10'h001;
  localparam logic [9:0]  VEC_LAST     = 10'h00B;
  // source index (vector minus one)
  localparam int          SRC_EXT0     = 0;
  localparam int          SRC_PCHG     = 1;
  localparam int          SRC_T1CA     = 2;
  localparam int          SRC_T1CB     = 3;
  localparam int          SRC_T1OV     = 4;
  localparam int          SRC_T0OV     = 5;
  localparam int          SRC_SSTART   = 6;
  localparam int          SRC_SOVF     = 7;
  localparam int          SRC_EERDY    = 8;
  localparam int          SRC_COMP     = 9;
  localparam int          SRC_CONV     = 10;
  // general mask bits
  localparam int          GM_EXT0      = 0;
  localparam int          GM_PCHG      = 1;
  localparam int          GM_SSTART    = 2;
  localparam int          GM_SOVF      = 3;
  localparam int          GM_EERDY     = 4;
  localparam int          GM_COMP      = 5;
  localparam int          GM_CONV      = 6;
  // timer mask bits
  localparam int          TM_T1CA      = 0;
  localparam int          TM_T1CB      = 1;
  localparam int          TM_T1OV      = 2;
  localparam int          TM_T0OV      = 3;
  // register byte addresses
  localparam logic [7:0]  OFS_GMASK    = 8'h00;
  localparam logic [7:0]  OFS_TMASK    = 8'h04;
  localparam logic [7:0]  OFS_FLAGS    = 8'h08;
  localparam logic [7:0]  OFS_CTRL     = 8'h0C;
  localparam logic [7:0]  OFS_EVSTAT   = 8'h10;
  localparam logic [7:0]  OFS_EVMASK   = 8'h14;
  localparam logic [7:0]  OFS_VECTOR   = 8'h18;
  // reset values
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [10:0] RST_FLAGS    = 11'h000;
  localparam logic        RST_GIE      = 1'b0;
  localparam logic [1:0]  RST_EV       = 2'h0;
  // event status bits
  localparam int          EV_ENTRY     = 0;
  localparam int          EV_RETURN    = 1;
  // interrupt entry length in clock cycles
  localparam logic [2:0]  ENTRY_CYCLES = 3'h4;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// file: verilog/irq_entry_seq.sv
// interrupt entry sequencer: holds the core busy while the pc is pushed
`timescale 1ns/1ps
`default_nettype none
module irq_entry_seq import irq_pkg::*; (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic start,
  output logic      busy,
  output logic      push
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       push_reg;
  logic       push_next;

  // load the entry length on start, count down to idle
  always_comb begin
    cnt_next  = cnt_reg;
    push_next = start;
    if (start) begin
      cnt_next = ENTRY_CYCLES;
    end else if (cnt_reg != 3'h0) begin
      cnt_next = cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 3'h0;
      push_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      push_reg <= push_next;
    end
  end

  assign busy = (cnt_reg != 3'h0);
  assign push = push_reg;
endmodule
`default_nettype wire

// file: verilog/vectored_interrupt_unit.sv
// vectored interrupt unit with axi4-lite register access
// Behaviour
// - eleven sources plus reset, each with its own vector
// - a source requests only with its enable and the global enable set
// - lowest vector wins; reset highest, then external request zero
// - vectors 0x000 to 0x00B in the fixed source order
// - enables live in a general mask and a timer mask, 8 bits each
// - accepting an interrupt clears the global enable
// - setting global enable inside a handler allows nesting
// - return from interrupt sets the global enable
// - loading the vector clears that source's pending flag
// - writing one to a flag clears it, zero leaves it
// - events set flags even when disabled; flags stay until served
// - entry takes at least four cycles while the pc is pushed
// - a multicycle instruction completes before the interrupt is taken
// - after return one main instruction runs before any interrupt
// - flags held while globally disabled are served later by priority
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_unit import irq_pkg::*; (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [10:0]       src_evt,
  input  wire logic              instr_boundary,
  input  wire logic              return_from_irq,
  output logic [VEC_W-1:0]       vector_addr,
  output logic                   take_strobe,
  output logic                   pc_push,
  output logic                   entry_busy,
  output logic                   irq
);
  // axi write and read channel state
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic              awfull_reg, awfull_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic              wstrb0_reg, wstrb0_next;
  logic              wfull_reg, wfull_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  // block state
  logic [7:0]        general_irq_mask_reg, general_irq_mask_next;
  logic [7:0]        timer_irq_mask_reg, timer_irq_mask_next;
  logic [10:0]       flag_reg, flag_next;
  logic              gie_reg, gie_next;
  logic [1:0]        evstat_reg, evstat_next;
  logic [1:0]        evmask_reg, evmask_next;
  logic              hold_reg, hold_next;
  logic              rst_pend_reg, rst_pend_next;
  logic [VEC_W-1:0]  vec_reg, vec_next;
  logic              take_reg, take_next;
  // decoded helpers
  logic              wr_do, rd_do;
  logic [10:0]       enable, req_vec, w1c;
  logic [3:0]        win_idx;
  logic              any_req, accept;
  logic              ev_entry, ev_return;

  assign wr_do = awfull_reg && wfull_reg && !bvalid_reg;
  assign rd_do = s_axi_arvalid && s_axi_arready;

  // per-source enable assembled from the two mask registers
  always_comb begin
    enable              = 11'h000;
    enable[SRC_EXT0]    = general_irq_mask_reg[GM_EXT0];
    enable[SRC_PCHG]    = general_irq_mask_reg[GM_PCHG];
    enable[SRC_T1CA]    = timer_irq_mask_reg[TM_T1CA];
    enable[SRC_T1CB]    = timer_irq_mask_reg[TM_T1CB];
    enable[SRC_T1OV]    = timer_irq_mask_reg[TM_T1OV];
    enable[SRC_T0OV]    = timer_irq_mask_reg[TM_T0OV];
    enable[SRC_SSTART]  = general_irq_mask_reg[GM_SSTART];
    enable[SRC_SOVF]    = general_irq_mask_reg[GM_SOVF];
    enable[SRC_EERDY]   = general_irq_mask_reg[GM_EERDY];
    enable[SRC_COMP]    = general_irq_mask_reg[GM_COMP];
    enable[SRC_CONV]    = general_irq_mask_reg[GM_CONV];
  end

  // requests gated by own and global enable
  assign req_vec = gie_reg ? (flag_reg & enable) : 11'h000;
  assign any_req = |req_vec;

  // lowest index, hence lowest vector, wins
  always_comb begin
    win_idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req_vec[i]) begin
        win_idx = 4'(i);
      end
    end
  end

  // accept only on an instruction boundary, out of entry, not straight
  // after a return, and after the reset vector
  assign accept = any_req && instr_boundary && !hold_reg && !entry_busy
                  && !rst_pend_reg;

  // entry sequencer keeps the core busy while the pc is pushed
  irq_entry_seq u_seq (
    .clk   (clk),
    .nrst  (nrst),
    .start (accept),
    .busy  (entry_busy),
    .push  (pc_push)
  );

  // axi write and read channel next state
  always_comb begin
    awaddr_next = awaddr_reg;
    awfull_next = awfull_reg;
    wdata_next  = wdata_reg;
    wstrb0_next = wstrb0_reg;
    wfull_next  = wfull_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      awfull_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next  = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
      wfull_next  = 1'b1;
    end
    if (wr_do) begin
      awfull_next = 1'b0;
      wfull_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (awaddr_reg[7:2] > OFS_EVMASK[7:2] || awaddr_reg[1:0] != 2'h0) begin
        bresp_next = RESP_SLVERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (rd_do) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_GMASK:  rdata_next = {24'h000000, general_irq_mask_reg};
        OFS_TMASK:  rdata_next = {24'h000000, timer_irq_mask_reg};
        OFS_FLAGS:  rdata_next = {21'h000000, flag_reg};
        OFS_CTRL:   rdata_next = {30'h00000000, hold_reg, gie_reg};
        OFS_EVSTAT: rdata_next = {30'h00000000, evstat_reg};
        OFS_EVMASK: rdata_next = {30'h00000000, evmask_reg};
        OFS_VECTOR: rdata_next = {22'h000000, vec_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awaddr_reg <= 8'h00;
      awfull_reg <= 1'b0;
      wdata_reg  <= 32'h00000000;
      wstrb0_reg <= 1'b0;
      wfull_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else begin
      awaddr_reg <= awaddr_next;
      awfull_reg <= awfull_next;
      wdata_reg  <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      wfull_reg  <= wfull_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign s_axi_awready = !awfull_reg;
  assign s_axi_wready  = !wfull_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // write-one-to-clear mask for the pending flags
  assign w1c = (wr_do && wstrb0_reg && awaddr_reg == OFS_FLAGS)
               ? wdata_reg[10:0] : 11'h000;
  assign ev_entry  = accept;
  assign ev_return = return_from_irq;

  // register file, flags, global enable and vector next state
  always_comb begin
    general_irq_mask_next = general_irq_mask_reg;
    timer_irq_mask_next   = timer_irq_mask_reg;
    gie_next              = gie_reg;
    evmask_next           = evmask_reg;
    hold_next             = hold_reg;
    rst_pend_next         = 1'b0;
    vec_next              = vec_reg;
    take_next             = 1'b0;
    // clears first, then sets, so a new event always survives
    flag_next  = flag_reg & ~w1c;
    if (accept) begin
      flag_next[win_idx] = 1'b0;
    end
    flag_next  = flag_next | src_evt;
    evstat_next = evstat_reg;
    if (wr_do && wstrb0_reg && awaddr_reg == OFS_EVSTAT) begin
      evstat_next = evstat_reg & ~wdata_reg[1:0];
    end
    evstat_next[EV_ENTRY]  = evstat_next[EV_ENTRY] | ev_entry;
    evstat_next[EV_RETURN] = evstat_next[EV_RETURN] | ev_return;
    if (wr_do && wstrb0_reg) begin
      case (awaddr_reg)
        OFS_GMASK:  general_irq_mask_next = wdata_reg[7:0];
        OFS_TMASK:  timer_irq_mask_next   = wdata_reg[7:0];
        OFS_CTRL:   gie_next              = wdata_reg[0];
        OFS_EVMASK: evmask_next           = wdata_reg[1:0];
        default: begin
        end
      endcase
    end
    if (return_from_irq) begin
      gie_next  = 1'b1;
      hold_next = 1'b1;
    end else if (hold_reg && instr_boundary) begin
      hold_next = 1'b0;
    end
    if (rst_pend_reg) begin
      vec_next  = VEC_RESET;
      take_next = 1'b1;
    end
    if (accept) begin
      gie_next  = 1'b0;
      vec_next  = VEC_FIRST + {6'h00, win_idx};
      take_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      general_irq_mask_reg <= RST_MASK;
      timer_irq_mask_reg   <= RST_MASK;
      flag_reg             <= RST_FLAGS;
      gie_reg              <= RST_GIE;
      evstat_reg           <= RST_EV;
      evmask_reg           <= RST_EV;
      hold_reg             <= 1'b0;
      rst_pend_reg         <= 1'b1;
      vec_reg              <= VEC_RESET;
      take_reg             <= 1'b0;
    end else begin
      general_irq_mask_reg <= general_irq_mask_next;
      timer_irq_mask_reg   <= timer_irq_mask_next;
      flag_reg             <= flag_next;
      gie_reg              <= gie_next;
      evstat_reg           <= evstat_next;
      evmask_reg           <= evmask_next;
      hold_reg             <= hold_next;
      rst_pend_reg         <= rst_pend_next;
      vec_reg              <= vec_next;
      take_reg             <= take_next;
    end
  end

  assign vector_addr = vec_reg;
  assign take_strobe = take_reg;
  assign irq         = |(evstat_reg & evmask_reg);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_entry;
    take_strobe && pc_push && entry_busy ##1 entry_busy [*3];
  endsequence

  a_entry_min_len: assert property (accept |=> s_entry)
    else $error("entry shorter than four cycles");
  a_take_one_cycle: assert property (
    accept |=> take_strobe && vector_addr == VEC_FIRST + $past(win_idx)
               ##1 !take_strobe)
    else $error("take strobe or vector wrong");
  a_gie_cleared_entry: assert property (accept |=> !gie_reg)
    else $error("global enable not cleared on entry");
  a_return_sets_gie: assert property (
    return_from_irq && !accept |=> gie_reg)
    else $error("return did not set global enable");
  a_flag_hw_clear: assert property (
    accept && !src_evt[win_idx] |=> !flag_reg[$past(win_idx)])
    else $error("served flag not cleared");
  a_gated_request: assert property (
    accept |-> gie_reg && (flag_reg & enable) != 11'h000)
    else $error("disabled request accepted");
  a_priority_low: assert property (
    accept |-> (req_vec & ((11'h001 << win_idx) - 11'h001)) == 11'h000)
    else $error("lower vector request skipped");
  a_boundary_only: assert property (accept |-> instr_boundary)
    else $error("accepted inside an instruction");
  a_one_instr_after: assert property (
    return_from_irq |=> !accept)
    else $error("interrupt taken right after return");
  a_flag_sticky: assert property (
    src_evt != 11'h000 |=> (flag_reg & $past(src_evt)) == $past(src_evt))
    else $error("event lost");
  a_w1c_clear: assert property (
    w1c != 11'h000 && src_evt == 11'h000 && !accept
    |=> (flag_reg & $past(w1c)) == 11'h000)
    else $error("write one did not clear flag");
  a_reset_vector: assert property (
    rst_pend_reg |=> take_strobe && vector_addr == VEC_RESET)
    else $error("reset vector not presented");
endmodule
`default_nettype wire

// file: test/core_model.sv
// core sequencer model: instruction boundaries and return pulses
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] gap,
  input  wire logic       ret_req,
  input  wire logic       take_strobe,
  input  wire logic       entry_busy,
  output logic            instr_boundary,
  output logic            return_from_irq,
  output logic [7:0]      bnd_since_ret
);
  logic [3:0] cnt_reg;
  logic       bnd_reg;
  // no instruction completes while the pc is loaded and pushed
  assign instr_boundary = bnd_reg && !take_strobe && !entry_busy;
  // gap idle cycles model a multicycle instruction before each boundary
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg         <= 4'h0;
      bnd_reg         <= 1'b0;
      return_from_irq <= 1'b0;
      bnd_since_ret   <= 8'h00;
    end else begin
      return_from_irq <= ret_req;
      if (cnt_reg >= gap) begin
        bnd_reg <= 1'b1;
        cnt_reg <= 4'h0;
      end else begin
        bnd_reg <= 1'b0;
        cnt_reg <= cnt_reg + 4'h1;
      end
      // boundaries after the return, its own one not counted
      if (return_from_irq)
        bnd_since_ret <= 8'h00;
      else if (instr_boundary && bnd_since_ret != 8'hFF)
        bnd_since_ret <= bnd_since_ret + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module testbench import irq_pkg::*;;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ret_req;
  logic [7:0]  awaddr, araddr, bsr, last_bsr, busy_cnt;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic [10:0] src_evt;
  logic [9:0]  vector_addr, last_vec;
  logic [3:0]  gap;
  logic        take_strobe, pc_push, entry_busy, irq, ib, rfi;
  logic        last_push, last_bnd, bnd_d;
  int          err_total, checked, takes, seen, cyc;

  vectored_interrupt_unit vectored_interrupt_unit_inst (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_evt(src_evt), .instr_boundary(ib), .return_from_irq(rfi),
    .vector_addr(vector_addr), .take_strobe(take_strobe), .pc_push(pc_push),
    .entry_busy(entry_busy), .irq(irq));

  core_model core_model_inst (
    .clk(clk), .nrst(nrst), .gap(gap), .ret_req(ret_req),
    .take_strobe(take_strobe), .entry_busy(entry_busy),
    .instr_boundary(ib), .return_from_irq(rfi), .bnd_since_ret(bsr));

  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // records each take and the cycles around it
  always @(posedge clk) begin
    bnd_d <= ib;
    busy_cnt <= take_strobe ? {7'h00, entry_busy} : busy_cnt + 8'(entry_busy);
    if (take_strobe) begin
      takes <= takes + 1;
      last_vec <= vector_addr;
      last_push <= pc_push;
      last_bnd <= bnd_d;
      last_bsr <= bsr;
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd && bvalid));
    rr = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic took;
    took = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (!took && arready) begin
        took = 1'b1;
        arvalid <= 1'b0;
      end
    end while (!(took && rvalid));
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d);
    chk("bresp", 32'(RESP_OKAY), 32'(rr));
  endtask

  task automatic rc(input string nm, logic [7:0] a, logic [31:0] e);
    axi_rd(a);
    chk("rresp", 32'(RESP_OKAY), 32'(rr));
    chk(nm, e, rd);
  endtask

  task automatic pulse(input logic [10:0] e);
    src_evt <= e;
    @(posedge clk);
    src_evt <= 11'h000;
  endtask

  task automatic take_chk(input logic [9:0] ev);
    while (takes <= seen) @(posedge clk);
    seen = takes;
    repeat (6) @(posedge clk);
    chk("vector", 32'(ev), 32'(last_vec));
    chk("pc push", 32'h1, 32'(last_push));
    chk("taken at boundary", 32'h1, 32'(last_bnd));
    chk("entry cycles", 32'h4, 32'(busy_cnt));
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ret_req} = 6'h00;
    {awaddr, araddr, wdata, src_evt, gap} = '0;
    {err_total, checked, takes, seen, cyc} = '0;
    nrst = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset takes", 32'h1, 32'(takes));
    chk("reset vector", 32'(VEC_RESET), 32'(last_vec));
    chk("reset push", 32'h0, 32'(last_push));
    seen = takes;
    rc("gmask", OFS_GMASK, 32'h0);
    rc("tmask", OFS_TMASK, 32'h0);
    rc("ctrl", OFS_CTRL, 32'h0);
    $display("test reset done");
    // disabled events are remembered but not taken
    wr(OFS_CTRL, 32'h1);
    pulse(11'h7FF);
    repeat (20) @(posedge clk);
    chk("no take", 32'(seen), 32'(takes));
    rc("flags held", OFS_FLAGS, 32'h7FF);
    wr(OFS_FLAGS, 32'h400);
    rc("flag w1c", OFS_FLAGS, 32'h3FF);
    wr(OFS_FLAGS, 32'h0);
    rc("flag w0", OFS_FLAGS, 32'h3FF);
    pulse(11'h400);
    $display("test flags done");
    // timer source T1CA first, then the rest in priority order with nesting
    wr(OFS_TMASK, 32'hF);
    take_chk(10'h003);
    rc("gie cleared", OFS_CTRL, 32'h0);
    rc("flag served", OFS_FLAGS, 32'h7FB);
    wr(OFS_GMASK, 32'h7F);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i != SRC_T1CA) begin
        wr(OFS_CTRL, 32'h1);
        take_chk(10'(i + 1));
      end
    end
    rc("flags empty", OFS_FLAGS, 32'h0);
    $display("test priority done");
    // entry event drives the interrupt line through its mask
    rc("event status", OFS_EVSTAT, 32'h1);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFS_EVMASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(OFS_EVSTAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test irq done");
    // return sets global enable; one main instruction before next take
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (4) @(posedge clk);
    rc("gie on return", OFS_CTRL, 32'h1);
    pulse(11'h001);
    take_chk(VEC_FIRST);
    gap <= 4'h6;
    pulse(11'h002);
    repeat (20) @(posedge clk);
    chk("held in handler", 32'(seen), 32'(takes));
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    take_chk(10'h002);
    chk("main instr", 32'h1, 32'(last_bsr >= 8'h02));
    rc("vector reg", OFS_VECTOR, 32'h002);
    $display("test return done");
    axi_wr(8'h1C, 32'h1);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rr));
    axi_rd(8'h1C);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rr));
    $display("test unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
